// ### verilog/cosc_pkg.sv
// Overview of operation
// - Base node number comes from input pins
// - Occupies up to 32 consecutive node numbers
// - Timing scales from configured system clock frequency
// - Bit rate 1M/500k/250k/125k, timing from frequency
// - SDO set: expedited, segmented or block
// - SDO identifiers derived from node number
// - Direct mode: internal dictionary, no initialisation
// - Sync window nonzero microseconds when enabled
// - Consume heartbeat of one producer, millisecond timeout
// - Produce own heartbeat at millisecond period
// - Switch bus after configured heartbeat event count
// - Stop switching after configured switch maximum
// - Four receive PDOs, exist and sync type
// - Four transmit PDOs, individually enabled
// - Synchronous transmit type accepts 1 to 240
// - Transmit PDO identifiers derived from node number
// - Asynchronous event timer counts 1 ms steps
// - Event and inhibit timers step per ms tick
// - Only unsigned 8/16/32 objects, no implicit arrays
// - Index 6xxxh read-write, 7xxxh read-only
// - Sample node inputs first eight cycles after reset
// - Node count code doubles, 000=1 to 101=32
package cosc_pkg;
  // Clock and time base
  localparam int SYS_FREQ_KHZ  = 100000;
  localparam int CLK_PERIOD_PS = 1000000000 / SYS_FREQ_KHZ;
  localparam int US_TIME_PS    = 1000000;
  localparam int MS_TIME_US    = 1000;
  localparam int US_CYCLES     = US_TIME_PS / CLK_PERIOD_PS;
  localparam int MS_CYCLES     = US_CYCLES * MS_TIME_US;
  localparam int NODE_SAMPLE_CYCLES = 8;
  localparam int INHIBIT_PER_MS     = 10;
  localparam int SYNC_TYPE_MAX      = 240;
  localparam int MAX_NODE_CODE      = 5;
  // Bit timing, time quanta per bit
  localparam int TQ_PER_BIT = 10;
  localparam logic [3:0] PHASE_ONE_TQ = 4'h4;
  localparam logic [3:0] PHASE_TWO_TQ = 4'h3;
  localparam logic [1:0] RESYNC_TQ    = 2'h1;
  // Predefined connection set
  localparam logic [10:0] COB_SDO_TX  = 11'h580;
  localparam logic [10:0] COB_SDO_RX  = 11'h600;
  localparam logic [10:0] COB_TPDO    = 11'h180;
  localparam logic [10:0] COB_PDO_STEP = 11'h100;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_SYNC_WIN = 8'h08;
  localparam logic [7:0] REG_HB_CONS  = 8'h0c;
  localparam logic [7:0] REG_HB_PROD  = 8'h10;
  localparam logic [7:0] REG_BUS_MGR  = 8'h14;
  localparam logic [7:0] REG_PDO_EN   = 8'h18;
  localparam logic [7:0] REG_TPDO_CFG = 8'h20;
  localparam logic [7:0] REG_SDO_ID   = 8'h30;
  localparam logic [7:0] REG_BIT_TIME = 8'h34;
  localparam logic [7:0] REG_AO_CHECK = 8'h38;
  localparam logic [7:0] REG_TPDO_ID  = 8'h40;
  // Field positions and reset values
  localparam int CTRL_SDO_LSB  = 2;
  localparam int CTRL_DIRECT   = 4;
  localparam int CTRL_WIN_EN   = 5;
  localparam int AO_TYPE_LSB   = 16;
  localparam int AO_IMPLICIT   = 18;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] BUS_MGR_RESET = 32'h0000_0303;

  typedef enum logic [1:0] {SDO_EXP, SDO_SEG, SDO_BLK, SDO_RSVD} cosc_sdo_type;

  function automatic logic [7:0] baud_prescaler(input logic [1:0] rate);
    int kbps;
    kbps = 1000 >> rate;
    baud_prescaler = 8'(SYS_FREQ_KHZ / (kbps * TQ_PER_BIT) - 1);
  endfunction

  function automatic logic [10:0] cob_id(input logic [10:0] base, input logic [6:0] node);
    cob_id = base + {4'h0, node};
  endfunction
endpackage

// ### verilog/cosc_tick_if.sv
`timescale 1ns/1ps
interface cosc_tick_if;
  logic us_tick;
  logic ms_tick;
  modport src (output us_tick, output ms_tick);
  modport dst (input us_tick, input ms_tick);
endinterface // cosc_tick_if

// ### verilog/cosc_tick.sv
`timescale 1ns/1ps
module cosc_tick
  import cosc_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  // System
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  // Ticks
  cosc_tick_if.src    tick
);
  logic [31:0] us_cnt;
  logic [31:0] ms_cnt;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      us_cnt       <= 32'h0;
      tick.us_tick <= 1'b0;
    end else begin
      tick.us_tick <= (us_cnt == 32'(US_CYCLES - 1));
      us_cnt       <= (us_cnt == 32'(US_CYCLES - 1)) ? 32'h0 : us_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ms_cnt       <= 32'h0;
      tick.ms_tick <= 1'b0;
    end else begin
      tick.ms_tick <= (ms_cnt == 32'(MS_COUNT - 1));
      ms_cnt       <= (ms_cnt == 32'(MS_COUNT - 1)) ? 32'h0 : ms_cnt + 32'h1;
    end
  end
endmodule // cosc_tick

// ### verilog/cosc_hb_guard.sv
`timescale 1ns/1ps
module cosc_hb_guard (
  // System
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ms_tick_i,
  // Heartbeat reception
  input  wire logic        hb_rx_i,
  input  wire logic [6:0]  hb_rx_node_i,
  // Settings
  input  wire logic [6:0]  prod_node_i,
  input  wire logic [15:0] cons_ms_i,
  input  wire logic [7:0]  ttoggle_i,
  input  wire logic [7:0]  ntoggle_i,
  input  wire logic        default_bus_i,
  // State
  output logic             bus_sel_o,
  output logic             hb_lost_o,
  output logic [7:0]       switch_count_o
);
  logic [15:0] age;
  logic [7:0]  events;
  logic        timeout;

  assign timeout = ms_tick_i && cons_ms_i != 16'h0 && age + 16'h1 >= cons_ms_i;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      age       <= 16'h0;
      hb_lost_o <= 1'b0;
    end else if (hb_rx_i && hb_rx_node_i == prod_node_i) begin
      age       <= 16'h0;
      hb_lost_o <= 1'b0;
    end else if (timeout) begin
      age       <= 16'h0;
      hb_lost_o <= 1'b1;
    end else if (ms_tick_i && cons_ms_i != 16'h0) begin
      age <= age + 16'h1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      events         <= 8'h0;
      switch_count_o <= 8'h0;
      bus_sel_o      <= 1'b0;
    end else if (timeout) begin
      if (events + 8'h1 >= ttoggle_i) begin
        events <= 8'h0;
        if (switch_count_o < ntoggle_i) begin
          bus_sel_o      <= ~bus_sel_o;
          switch_count_o <= switch_count_o + 8'h1;
        end
      end else begin
        events <= events + 8'h1;
      end
    end else if (switch_count_o == 8'h0) begin
      bus_sel_o <= default_bus_i;
    end
  end
endmodule // cosc_hb_guard

// ### verilog/cosc_top.sv
`timescale 1ns/1ps
module cosc_top
  import cosc_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  // System
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // Node identity straps
  input  wire logic [6:0]  base_node_number_i,
  input  wire logic [2:0]  node_count_code_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Network events
  input  wire logic        sync_i,
  input  wire logic        hb_rx_i,
  input  wire logic [6:0]  hb_rx_node_i,
  input  wire logic [3:0]  tpdo_req_i,
  input  wire logic [3:0]  rpdo_rx_i,
  // Service outputs
  output logic             bus_sel_o,
  output logic             hb_tx_o,
  output logic [3:0]       tpdo_fire_o,
  output logic [3:0]       rpdo_apply_o,
  output logic             sync_window_o,
  output logic             sdo_seg_en_o,
  output logic             sdo_blk_en_o,
  output logic             od_init_skip_o
);
  cosc_tick_if tick ();

  logic [31:0] ctrl;
  logic [15:0] sync_win_us;
  logic [6:0]  prod_node;
  logic [15:0] cons_ms;
  logic [15:0] prod_ms;
  logic [31:0] bus_mgr;
  logic [11:0] pdo_en;
  logic [31:0] tpdo_cfg [4];
  logic [19:0] ao_req;
  logic [6:0]  base_node;
  logic [2:0]  count_code;
  logic [3:0]  sample_cnt;
  logic        hb_lost;
  logic [7:0]  switch_count;
  logic [15:0] win_cnt;
  logic [15:0] prod_cnt;
  logic [7:0]  sync_cnt [4];
  logic [15:0] evt_cnt [4];
  logic [4:0]  inh_cnt [4];
  logic [3:0]  pend;
  logic [3:0]  rpdo_pend;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] next_rdata;
  cosc_sdo_type sdo_set;

  // Bus handshake and decode
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? val[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  function automatic logic [5:0] node_total(input logic [2:0] code);
    if (code > 3'(MAX_NODE_CODE)) begin
      node_total = 6'h20;
    end else begin
      node_total = 6'(6'h1 << code);
    end
  endfunction

  function automatic logic is_sync_type(input logic [7:0] t);
    is_sync_type = t >= 8'h1 && t <= 8'(SYNC_TYPE_MAX);
  endfunction

  // Node straps caught after reset release
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_cnt <= 4'h0;
      base_node  <= 7'h0;
      count_code <= 3'h0;
    end else if (sample_cnt < 4'(NODE_SAMPLE_CYCLES)) begin
      sample_cnt <= sample_cnt + 4'h1;
      base_node  <= base_node_number_i;
      count_code <= node_count_code_i;
    end
  end

  // Register writes
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl        <= CTRL_RESET;
      sync_win_us <= 16'h0;
      prod_node   <= 7'h0;
      cons_ms     <= 16'h0;
      prod_ms     <= 16'h0;
      bus_mgr     <= BUS_MGR_RESET;
      pdo_en      <= 12'h0;
      ao_req      <= 20'h0;
      for (int i = 0; i < 4; i++) begin
        tpdo_cfg[i] <= 32'h0;
      end
    end else if (wb_wr) begin
      case (wb_adr_i)
        REG_CTRL:     ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
        REG_SYNC_WIN: sync_win_us <= 16'(merge({16'h0, sync_win_us}, wb_dat_i, wb_sel_i));
        REG_HB_CONS: begin
          if (wb_sel_i[0]) begin
            prod_node <= wb_dat_i[6:0];
          end
          cons_ms <= 16'(merge({cons_ms, 16'h0}, wb_dat_i, wb_sel_i) >> 16);
        end
        REG_HB_PROD:  prod_ms <= 16'(merge({16'h0, prod_ms}, wb_dat_i, wb_sel_i));
        REG_BUS_MGR:  bus_mgr <= merge(bus_mgr, wb_dat_i, wb_sel_i);
        REG_PDO_EN:   pdo_en <= 12'(merge({20'h0, pdo_en}, wb_dat_i, wb_sel_i));
        REG_AO_CHECK: ao_req <= 20'(merge({12'h0, ao_req}, wb_dat_i, wb_sel_i));
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == REG_TPDO_CFG + 8'(4 * i)) begin
              tpdo_cfg[i] <= merge(tpdo_cfg[i], wb_dat_i, wb_sel_i);
            end
          end
        end
      endcase
    end
  end

  // Service set selection
  always_comb begin
    sdo_set = cosc_sdo_type'(ctrl[CTRL_SDO_LSB +: 2]);
    if (ctrl[CTRL_DIRECT] || sdo_set == SDO_RSVD) begin
      sdo_set = SDO_EXP;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdo_seg_en_o   <= 1'b0;
      sdo_blk_en_o   <= 1'b0;
      od_init_skip_o <= 1'b0;
    end else begin
      sdo_seg_en_o   <= (sdo_set == SDO_SEG);
      sdo_blk_en_o   <= (sdo_set == SDO_BLK);
      od_init_skip_o <= ctrl[CTRL_DIRECT];
    end
  end

  // Read data
  always_comb begin
    next_rdata = 32'h0;
    case (wb_adr_i)
      REG_CTRL:     next_rdata = ctrl;
      REG_STATUS:   next_rdata = {7'h0, sample_cnt >= 4'(NODE_SAMPLE_CYCLES), switch_count,
                                  hb_lost, bus_sel_o, node_total(count_code), 1'b0, base_node};
      REG_SYNC_WIN: next_rdata = {16'h0, sync_win_us};
      REG_HB_CONS:  next_rdata = {cons_ms, 9'h0, prod_node};
      REG_HB_PROD:  next_rdata = {16'h0, prod_ms};
      REG_BUS_MGR:  next_rdata = bus_mgr;
      REG_PDO_EN:   next_rdata = {20'h0, pdo_en};
      REG_SDO_ID:   next_rdata = {5'h0, cob_id(COB_SDO_TX, base_node),
                                  5'h0, cob_id(COB_SDO_RX, base_node)};
      REG_BIT_TIME: next_rdata = {14'h0, RESYNC_TQ, PHASE_TWO_TQ, PHASE_ONE_TQ,
                                  baud_prescaler(ctrl[1:0])};
      REG_AO_CHECK: begin
        next_rdata[19:0] = ao_req;
        next_rdata[20]   = ao_req[AO_TYPE_LSB +: 2] != 2'h3 && !ao_req[AO_IMPLICIT];
        next_rdata[21]   = ao_req[15:12] == 4'h6;
        next_rdata[22]   = ao_req[15:12] == 4'h7;
      end
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (wb_adr_i == REG_TPDO_CFG + 8'(4 * i)) begin
            next_rdata = tpdo_cfg[i];
          end
          if (wb_adr_i == REG_TPDO_ID + 8'(4 * i)) begin
            next_rdata = {21'h0, cob_id(COB_TPDO + 11'(i) * COB_PDO_STEP, base_node)};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // Time base
  cosc_tick #(
    .MS_COUNT (MS_COUNT)
  ) u_tick (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .tick      (tick.src)
  );

  // Heartbeat consumer and bus redundancy
  cosc_hb_guard u_guard (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .ms_tick_i      (tick.ms_tick),
    .hb_rx_i        (hb_rx_i),
    .hb_rx_node_i   (hb_rx_node_i),
    .prod_node_i    (prod_node),
    .cons_ms_i      (cons_ms),
    .ttoggle_i      (bus_mgr[7:0]),
    .ntoggle_i      (bus_mgr[15:8]),
    .default_bus_i  (bus_mgr[16]),
    .bus_sel_o      (bus_sel_o),
    .hb_lost_o      (hb_lost),
    .switch_count_o (switch_count)
  );

  // Heartbeat producer
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prod_cnt <= 16'h0;
      hb_tx_o  <= 1'b0;
    end else begin
      hb_tx_o <= 1'b0;
      if (prod_ms == 16'h0) begin
        prod_cnt <= 16'h0;
      end else if (tick.ms_tick) begin
        if (prod_cnt + 16'h1 >= prod_ms) begin
          prod_cnt <= 16'h0;
          hb_tx_o  <= 1'b1;
        end else begin
          prod_cnt <= prod_cnt + 16'h1;
        end
      end
    end
  end

  // Synchronous window
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_cnt       <= 16'h0;
      sync_window_o <= 1'b0;
    end else begin
      if (!ctrl[CTRL_WIN_EN]) begin
        win_cnt <= 16'h0;
      end else if (sync_i) begin
        win_cnt <= sync_win_us;
      end else if (tick.us_tick && win_cnt != 16'h0) begin
        win_cnt <= win_cnt - 16'h1;
      end
      sync_window_o <= ctrl[CTRL_WIN_EN] && (sync_i ? sync_win_us != 16'h0 : win_cnt != 16'h0);
    end
  end

  // Receive PDOs
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rpdo_pend    <= 4'h0;
      rpdo_apply_o <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        rpdo_apply_o[i] <= pdo_en[4 + i] && ((!pdo_en[8 + i] && rpdo_rx_i[i]) ||
                                             (pdo_en[8 + i] && sync_i && rpdo_pend[i]));
        if (!pdo_en[4 + i]) begin
          rpdo_pend[i] <= 1'b0;
        end else if (pdo_en[8 + i] && rpdo_rx_i[i]) begin
          rpdo_pend[i] <= 1'b1;
        end else if (sync_i) begin
          rpdo_pend[i] <= 1'b0;
        end
      end
    end
  end

  // Transmit PDOs
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend        <= 4'h0;
      tpdo_fire_o <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        sync_cnt[i] <= 8'h0;
        evt_cnt[i]  <= 16'h0;
        inh_cnt[i]  <= 5'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        tpdo_fire_o[i] <= 1'b0;
        if (!pdo_en[i] || tpdo_cfg[i][7:0] == 8'h0) begin
          sync_cnt[i] <= 8'h0;
          evt_cnt[i]  <= 16'h0;
          inh_cnt[i]  <= 5'h0;
          pend[i]     <= 1'b0;
        end else if (is_sync_type(tpdo_cfg[i][7:0])) begin
          if (sync_i && sync_cnt[i] + 8'h1 >= tpdo_cfg[i][7:0]) begin
            sync_cnt[i]    <= 8'h0;
            tpdo_fire_o[i] <= 1'b1;
          end else if (sync_i) begin
            sync_cnt[i] <= sync_cnt[i] + 8'h1;
          end
        end else begin
          if (tick.ms_tick && inh_cnt[i] != 5'h0) begin
            inh_cnt[i] <= inh_cnt[i] - 5'h1;
          end
          if (tick.ms_tick && tpdo_cfg[i][31:16] != 16'h0) begin
            evt_cnt[i] <= evt_cnt[i] + 16'h1;
          end
          if (pend[i] && inh_cnt[i] == 5'h0) begin
            tpdo_fire_o[i] <= 1'b1;
            pend[i]        <= 1'b0;
            evt_cnt[i]     <= 16'h0;
            inh_cnt[i]     <= 5'(tpdo_cfg[i][15:8] / 8'(INHIBIT_PER_MS));
          end
          if (tpdo_req_i[i] || (tick.ms_tick && tpdo_cfg[i][31:16] != 16'h0 &&
                                evt_cnt[i] + 16'h1 >= tpdo_cfg[i][31:16])) begin
            pend[i] <= 1'b1;
          end
        end
      end
    end
  end
endmodule // cosc_top

// ### sim/cosc_top_chk.sv
`timescale 1ns/1ps
module cosc_top_chk
  import cosc_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  // System
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Events
  input wire logic        sync_i,
  input wire logic [3:0]  rpdo_rx_i,
  input wire logic [3:0]  rpdo_apply_o,
  input wire logic [3:0]  tpdo_fire_o,
  input wire logic        hb_tx_o,
  input wire logic        bus_sel_o,
  input wire logic        sync_window_o,
  input wire logic        sdo_seg_en_o,
  input wire logic        sdo_blk_en_o,
  input wire logic        od_init_skip_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] gap;
  // Cycles since last own heartbeat, saturating
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      gap <= MS_COUNT;
    else if (hb_tx_o)
      gap <= 32'h1;
    else if (gap < MS_COUNT)
      gap <= gap + 32'h1;
  end
  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("no ack after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold;
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_sdo_excl;
    !(sdo_seg_en_o && sdo_blk_en_o);
  endproperty
  a_sdo_excl: assert property (p_sdo_excl) else $error("two sdo sets");
  property p_skip;
    od_init_skip_o |-> !sdo_seg_en_o && !sdo_blk_en_o;
  endproperty
  a_skip: assert property (p_skip) else $error("direct mode not expedited");
  property p_sync_win;
    $rose(sync_window_o) |-> $past(sync_i);
  endproperty
  a_sync_win: assert property (p_sync_win) else $error("window without sync");
  property p_rpdo_cause;
    |rpdo_apply_o |-> (rpdo_apply_o & ~($past(rpdo_rx_i) | {4{$past(sync_i)}})) == 4'h0;
  endproperty
  a_rpdo_cause: assert property (p_rpdo_cause) else $error("rpdo apply uncaused");
  property p_hb_gap;
    hb_tx_o |-> gap >= MS_COUNT;
  endproperty
  a_hb_gap: assert property (p_hb_gap) else $error("heartbeat too soon");
  c_hb: cover property (hb_tx_o);
  c_bus: cover property ($rose(bus_sel_o));
  c_tpdo: cover property (tpdo_fire_o[2]);
  c_win: cover property (sync_window_o);
endmodule // cosc_top_chk

bind cosc_top cosc_top_chk #(.MS_COUNT(MS_COUNT)) i_chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_i(sync_i),
  .rpdo_rx_i(rpdo_rx_i), .rpdo_apply_o(rpdo_apply_o), .tpdo_fire_o(tpdo_fire_o),
  .hb_tx_o(hb_tx_o), .bus_sel_o(bus_sel_o), .sync_window_o(sync_window_o),
  .sdo_seg_en_o(sdo_seg_en_o), .sdo_blk_en_o(sdo_blk_en_o), .od_init_skip_o(od_init_skip_o));

// ### sim/cosc_master_model.sv
`timescale 1ns/1ps
module cosc_master_model (
  // System
  input  wire logic  clock_i,
  // Network events
  output logic       sync_o,
  output logic       hb_o,
  output logic [6:0] hb_node_o,
  output logic [3:0] rpdo_o
);
  int         hb_period = 0;
  int         hb_cnt = 0;
  logic [6:0] hb_src = 7'h00;
  initial begin
    sync_o = 1'b0;
    hb_o = 1'b0;
    hb_node_o = 7'h00;
    rpdo_o = 4'h0;
  end
  // Periodic heartbeat; node lines toggle while idle
  always @(posedge clock_i) begin
    hb_cnt <= (hb_cnt + 1 >= hb_period) ? 0 : hb_cnt + 1;
    hb_o <= (hb_period > 0) && (hb_cnt == 0);
    hb_node_o <= (hb_period > 0 && hb_cnt == 0) ? hb_src : ~hb_node_o;
  end
  task automatic send_sync();
    @(posedge clock_i) sync_o <= 1'b1;
    @(posedge clock_i) sync_o <= 1'b0;
  endtask
  task automatic send_rpdo(input logic [3:0] ch);
    @(posedge clock_i) rpdo_o <= ch;
    @(posedge clock_i) rpdo_o <= 4'h0;
  endtask
endmodule // cosc_master_model

// ### sim/test_canopen_slave_config.sv
`timescale 1ns/1ps
module test_canopen_slave_config
  import cosc_pkg::*;
;
  localparam int MS_SIM = 20;
  logic        clock_i = 1'b0, sys_rst_i, wb_cyc_i, wb_stb_i;
  logic        wb_we_i, wb_ack_o, sync_i, hb_rx_i, bus_sel_o, hb_tx_o, sync_window_o;
  logic        sdo_seg_en_o, sdo_blk_en_o, od_init_skip_o;
  logic [6:0]  base_node_number_i, hb_rx_node_i, node;
  logic [2:0]  node_count_code_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, tpdo_req_i, rpdo_rx_i, tpdo_fire_o, rpdo_apply_o;
  logic [31:0] wb_dat_i, wb_dat_o, seed = 32'h77134988, w, cnt;
  logic [31:0] rd_q[$], mk_q[$];
  logic [7:0]  ev_q[$];
  int          n_fail = 0, samples_checked = 0, cycles = 0, k;

  cosc_top #(.MS_COUNT(MS_SIM)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .base_node_number_i(base_node_number_i), .node_count_code_i(node_count_code_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sync_i(sync_i), .hb_rx_i(hb_rx_i), .hb_rx_node_i(hb_rx_node_i), .tpdo_req_i(tpdo_req_i),
    .rpdo_rx_i(rpdo_rx_i), .bus_sel_o(bus_sel_o), .hb_tx_o(hb_tx_o), .tpdo_fire_o(tpdo_fire_o),
    .rpdo_apply_o(rpdo_apply_o), .sync_window_o(sync_window_o), .sdo_seg_en_o(sdo_seg_en_o),
    .sdo_blk_en_o(sdo_blk_en_o), .od_init_skip_o(od_init_skip_o));
  cosc_master_model i_master (.clock_i(clock_i), .sync_o(sync_i), .hb_o(hb_rx_i),
    .hb_node_o(hb_rx_node_i), .rpdo_o(rpdo_rx_i));

  always #5 clock_i = ~clock_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Classic single cycle; a read notes its expectation first
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] m);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    if (!we) begin
      rd_q.push_back(d & m);
      mk_q.push_back(m);
    end
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic req(input logic [3:0] ch);
    @(posedge clock_i) tpdo_req_i <= ch;
    @(posedge clock_i) tpdo_req_i <= 4'h0;
  endtask

  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
      check(rd_q.pop_front(), wb_dat_o & mk_q.pop_front());
    if (|{tpdo_fire_o, rpdo_apply_o} !== 1'b0)
      check({24'h0, ev_q.size() > 0 ? ev_q.pop_front() : 8'h00},
            {24'h0, tpdo_fire_o, rpdo_apply_o});
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 30000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, tpdo_req_i} = 51'h0;
    seed = lfsr(seed);
    node = seed[6:0];
    base_node_number_i = seed[6:0];
    node_count_code_i = seed[10:8];
    cnt = (seed[10:8] > 3'h5) ? 32'h20 : 32'h1 << seed[10:8];
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    base_node_number_i <= ~node;
    node_count_code_i <= ~seed[10:8];
    w = {7'h0, 1'b1, 10'h0, cnt[5:0], 1'b0, node};
    bus(0, REG_STATUS, w, 4'hf, 32'hffff_ffff);
    bus(1, REG_STATUS, ~w, 4'hf, 32'h0);
    bus(0, REG_STATUS, w, 4'hf, 32'hffff_ffff);
    bus(1, 8'hfc, 32'hffff_ffff, 4'hf, 32'h0);
    bus(0, 8'hfc, 32'h0, 4'hf, 32'hffff_ffff);
    bus(0, REG_SDO_ID, {5'h0, COB_SDO_TX + 11'(node), 5'h0, COB_SDO_RX + 11'(node)}, 4'hf,
        32'hffff_ffff);
    for (int i = 0; i < 4; i++)
      bus(0, REG_TPDO_ID + 8'(4 * i), {21'h0, COB_TPDO + 11'(i * 256) + 11'(node)}, 4'hf,
          32'hffff_ffff);
    bus(0, REG_CTRL, CTRL_RESET, 4'hf, 32'hffff_ffff);
    bus(0, REG_BUS_MGR, BUS_MGR_RESET, 4'hf, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      w = {27'h0, i[2], i[1:0], i[1:0]};
      bus(1, REG_CTRL, w, 4'hf, 32'h0);
      k = SYS_FREQ_KHZ / ((1000 >> i[1:0]) * 10) - 1;
      bus(0, REG_BIT_TIME, {14'h0, 2'h1, 4'h3, 4'h4, 8'(k)}, 4'hf, 32'hffff_ffff);
      check({29'h0, !i[2] && i[1:0] == 2'h1, !i[2] && i[1:0] == 2'h2, i[2]},
            {29'h0, sdo_seg_en_o, sdo_blk_en_o, od_init_skip_o});
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = {13'h0, i[1] ? 3'h5 : 3'(i), i[0] ? 4'h7 : 4'h6, seed[11:0]};
      bus(1, REG_AO_CHECK, w, 4'hf, 32'h0);
      bus(0, REG_AO_CHECK, {9'h0, w[15:12] == 4'h7, w[15:12] == 4'h6,
          w[17:16] != 2'h3 && !w[18], 1'b0, w[18:0]}, 4'hf, 32'hffff_ffff);
    end
    bus(1, REG_PDO_EN, 32'h1, 4'hf, 32'h0);
    bus(1, REG_TPDO_CFG, 32'hff, 4'hf, 32'h0);
    ev_q.push_back(8'h10);
    req(4'h3);
    repeat (5) @(posedge clock_i);
    bus(1, REG_TPDO_CFG, 32'h14ff, 4'hf, 32'h0);
    ev_q.push_back(8'h10);
    ev_q.push_back(8'h10);
    req(4'h1);
    req(4'h1);
    repeat (100) @(posedge clock_i);
    bus(1, REG_TPDO_CFG + 8'h08, 32'h2, 4'hf, 32'h0);
    bus(1, REG_PDO_EN, 32'h4, 4'hf, 32'h0);
    ev_q.push_back(8'h40);
    ev_q.push_back(8'h40);
    repeat (4) i_master.send_sync();
    repeat (5) @(posedge clock_i);
    bus(1, REG_PDO_EN, 32'h0230, 4'hf, 32'h0);
    ev_q.push_back(8'h01);
    i_master.send_rpdo(4'h7);
    repeat (5) @(posedge clock_i);
    ev_q.push_back(8'h02);
    i_master.send_sync();
    repeat (5) @(posedge clock_i);
    bus(1, REG_HB_PROD, 32'hffff_ff03, 4'h1, 32'h0);
    bus(0, REG_HB_PROD, 32'h3, 4'hf, 32'hffff_ffff);
    while (hb_tx_o !== 1'b1) @(posedge clock_i);
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (hb_tx_o !== 1'b1);
    check(3 * MS_SIM, k);
    bus(1, REG_HB_PROD, 32'h0, 4'hf, 32'h0);
    i_master.hb_src = 7'h05;
    i_master.hb_period = 20;
    bus(1, REG_BUS_MGR, 32'h0302, 4'hf, 32'h0);
    bus(1, REG_HB_CONS, 32'h0002_0005, 4'hf, 32'h0);
    repeat (300) @(posedge clock_i);
    bus(0, REG_STATUS, 32'h0, 4'hf, 32'h00ff_c000);
    i_master.hb_src = 7'h06;
    repeat (1000) @(posedge clock_i);
    bus(0, REG_STATUS, 32'h0003_c000, 4'hf, 32'h00ff_c000);
    check(32'h1, {31'h0, bus_sel_o});
    i_master.hb_period = 0;
    bus(1, REG_SYNC_WIN, 32'h2, 4'hf, 32'h0);
    bus(1, REG_CTRL, 32'h20, 4'hf, 32'h0);
    i_master.send_sync();
    repeat (50) @(posedge clock_i);
    check(32'h1, {31'h0, sync_window_o});
    repeat (350) @(posedge clock_i);
    check(32'h0, {31'h0, sync_window_o});
    bus(1, REG_CTRL, 32'h0, 4'hf, 32'h0);
    i_master.send_sync();
    repeat (3) @(posedge clock_i);
    check(32'h0, {31'h0, sync_window_o});
    check(32'h0, ev_q.size());
    end_sim();
  end
endmodule // test_canopen_slave_config
